/* dv/tmpc_apb_model.sv */
// partner: register-port master standing in for a debugger or on-chip software
`default_nettype none
module tmpc_apb_model (
  input wire logic clk_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out,
  output logic paddr_dbg_out,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // idle state
  // ----------------------------------------------------------------
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0000_0000;
    paddr_dbg_out = 1'b1;
  end
  // ----------------------------------------------------------------
  // one transfer: setup, access, hold until ready seen high
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic dbg, input logic [11:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata);
    int n;
    n = 0;
    @(negedge clk_in);
    psel_out = 1'b1;
    pwrite_out = wr;
    paddr_out = addr; // offsets taken from a base of zero
    pwdata_out = wdata;
    paddr_dbg_out = dbg; // debugger or software access
    @(negedge clk_in);
    penable_out = 1'b1;
    @(posedge clk_in);
    while (pready_in !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk_in);
    end
    rdata = prdata_in;
    @(negedge clk_in);
    psel_out = 1'b0;
    penable_out = 1'b0;
    // released lines toggle so a stale value is never mistaken for data
    paddr_out = ~paddr_out;
    pwdata_out = ~pwdata_out;
  endtask
endmodule
`default_nettype wire

/* dv/tmpc_top_test.sv */
// testbench: reset, programming mode and register port of the trace control block
`default_nettype none
module tmpc_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por_n = 1'b1;
  logic sys_rst = 1'b0;
  logic cpu_rst = 1'b0;
  logic psel, penable, pwrite, pdbg, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic wp_valid = 1'b0;
  logic [31:0] wp_data = 32'h0000_0000;
  logic [51:0] pmu = 52'h0;
  logic [3:0] ext_in = 4'h0;
  logic [1:0] ext_out;
  logic tv, tready = 1'b1;
  logic [31:0] td;
  logic dbg = 1'b1;
  int fail_count = 0;
  int checked = 0;
  logic [31:0] q[$];
  always #12.5 clk = ~clk;
  tmpc_apb_model tmpc_apb_model_i (.clk_in(clk), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .paddr_dbg_out(pdbg),
    .prdata_in(prdata), .pready_in(pready));
  tmpc_top tmpc_top_i (.clk_in(clk), .rst_in(rst), .power_on_reset_n_in(por_n),
    .sys_reset_in(sys_rst), .cpu_reset_in(cpu_rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .paddr_dbg_in(pdbg),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .waypoint_valid_in(wp_valid), .waypoint_data_in(wp_data), .pmu_event_in(pmu),
    .ext_in_in(ext_in), .ext_out_out(ext_out), .trace_valid_out(tv), .trace_data_out(td),
    .trace_ready_in(tready));
  // ----------------------------------------------------------------
  // trace sink and helpers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (tv === 1'b1 && tready === 1'b1) begin
      q.push_back(td);
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    tmpc_apb_model_i.xfer(1'b1, dbg, a, d, r);
    chk({31'h0, pready}, 32'h0000_0001);
  endtask
  // read first so reserved control bits are written back as read
  task automatic rmw(input logic [31:0] clr, input logic [31:0] set);
    logic [31:0] r, w;
    tmpc_apb_model_i.xfer(1'b0, dbg, tmpc_pkg::OFF_MAIN_CONTROL, 32'h0000_0000, r);
    tmpc_apb_model_i.xfer(1'b1, dbg, tmpc_pkg::OFF_MAIN_CONTROL, (r & ~clr) | set, w);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    tmpc_apb_model_i.xfer(1'b0, dbg, a, 32'h0000_0000, r);
    chk(r & m, e);
  endtask
  task automatic send(input int n, input logic [31:0] base);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      wp_valid = 1'b1;
      wp_data = base + 32'(i);
    end
    @(negedge clk);
    wp_valid = 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_q(input int n);
    for (int k = 0; k < 200 && q.size() < n; k++) @(negedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // watchdog: whole sequence needs a few hundred cycles
  // ----------------------------------------------------------------
  initial begin
    #(25 * 20000);
    fail_count++;
    summarize();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    idle(6);
    rst = 1'b0;
    idle(1);
    chk(32'(tmpc_pkg::PMU_EVENT_WIDTH), 32'h0000_0034);
    rd(tmpc_pkg::OFF_MAIN_CONTROL, 32'hFFFF_FFFF, tmpc_pkg::MAIN_CONTROL_RESET);
    rd(tmpc_pkg::OFF_SYNC_FREQ, 32'hFFFF_FFFF, 32'h0000_0400);
    rd(tmpc_pkg::OFF_TRACE_ID, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(tmpc_pkg::OFF_TRIGGER, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(tmpc_pkg::OFF_DEV_TYPE, 32'hFFFF_FFFF, 32'h0000_0013);
    rd(12'h004, 32'hFFFF_FFFF, 32'h0000_0000);
    dbg = 1'b0;
    rd(tmpc_pkg::OFF_LOCK_STATUS, 32'h0000_0003, 32'h0000_0003);
    chk({30'h0, ext_out}, 32'h0000_0000);
    // software write while locked is dropped, unlocked one lands
    wr(tmpc_pkg::OFF_TRIGGER, 32'h0000_0055);
    chk({31'h0, pslverr}, 32'h0000_0000);
    dbg = 1'b1;
    rd(tmpc_pkg::OFF_TRIGGER, 32'hFFFF_FFFF, 32'h0000_0000);
    dbg = 1'b0;
    wr(tmpc_pkg::OFF_LOCK_ACCESS, tmpc_pkg::LOCK_KEY);
    rd(tmpc_pkg::OFF_LOCK_STATUS, 32'h0000_0003, 32'h0000_0001);
    wr(tmpc_pkg::OFF_TRIGGER, 32'h0000_0055);
    dbg = 1'b1;
    rd(tmpc_pkg::OFF_TRIGGER, 32'hFFFF_FFFF, 32'h0000_0055);
    // counter frozen while programming
    wr(tmpc_pkg::OFF_EXT_IN_SEL, 32'h0000_3F00);
    wr(tmpc_pkg::OFF_COUNTER, 32'h0000_0005);
    @(negedge clk);
    pmu[0] = 1'b1;
    ext_in[0] = 1'b1;
    idle(4);
    pmu[0] = 1'b0;
    ext_in[0] = 1'b0;
    rd(tmpc_pkg::OFF_COUNTER, 32'h0000_FFFF, 32'h0000_0005);
    wr(tmpc_pkg::OFF_TRACE_EN_CTRL, 32'h0000_0001);
    wr(tmpc_pkg::OFF_TRACE_ID, 32'h0000_0011);
    rd(tmpc_pkg::OFF_STATUS, 32'h0000_0006, 32'h0000_0002);
    wr(tmpc_pkg::OFF_MAIN_CONTROL, 32'h0000_0000);
    @(negedge clk);
    pmu[0] = 1'b1;
    ext_in[0] = 1'b1;
    @(negedge clk);
    pmu[0] = 1'b0;
    ext_in[0] = 1'b0;
    rd(tmpc_pkg::OFF_COUNTER, 32'h0000_FFFF, 32'h0000_0004);
    rd(tmpc_pkg::OFF_STATUS, 32'h0000_0004, 32'h0000_0004);
    chk({30'h0, ext_out}, 32'h0000_0002);
    q.delete();
    send(3, 32'h0000_00A0);
    wait_q(3);
    chk(32'(q.size()), 32'h0000_0003);
    foreach (q[i]) chk(q[i], 32'h0000_00A0 + 32'(i));
    // overflow with the sink stalled
    q.delete();
    tready = 1'b0;
    send(25, 32'h0000_0100);
    rd(tmpc_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0001);
    tready = 1'b1;
    idle(60);
    chk(q.size() > 0 ? q[0] : 32'hFFFF_FFFF, 32'h0000_0100);
    chk(q.size() > 0 ? q[q.size()-1] : 32'h0, tmpc_pkg::OVERFLOW_MARK);
    // programming bit drains the fifo, then no more trace
    q.delete();
    tready = 1'b0;
    send(4, 32'h0000_0200);
    wr(tmpc_pkg::OFF_MAIN_CONTROL, 32'h0000_0400);
    send(4, 32'h0000_0300);
    rd(tmpc_pkg::OFF_STATUS, 32'h0000_0002, 32'h0000_0000);
    tready = 1'b1;
    idle(20);
    chk(32'(q.size()), 32'h0000_0004);
    rd(tmpc_pkg::OFF_STATUS, 32'h0000_0002, 32'h0000_0002);
    chk({30'h0, ext_out}, 32'h0000_0000);
    // macrocell reset stops trace and restores main control
    rmw(32'h0000_0400, 32'h0000_0000);
    por_n = 1'b0;
    idle(2);
    por_n = 1'b1;
    rd(tmpc_pkg::OFF_MAIN_CONTROL, 32'hFFFF_FFFF, tmpc_pkg::MAIN_CONTROL_RESET);
    rd(tmpc_pkg::OFF_TRACE_ID, 32'hFFFF_FFFF, 32'h0000_0000);
    q.delete();
    send(2, 32'h0000_0400);
    idle(10);
    chk(32'(q.size()), 32'h0000_0000);
    // system reset clears trigger but not main control
    wr(tmpc_pkg::OFF_TRIGGER, 32'h0000_0055);
    wr(tmpc_pkg::OFF_MAIN_CONTROL, 32'h0000_0400);
    sys_rst = 1'b1;
    idle(1);
    sys_rst = 1'b0;
    rd(tmpc_pkg::OFF_TRIGGER, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(tmpc_pkg::OFF_MAIN_CONTROL, 32'hFFFF_FFFF, 32'h0000_0400);
    // processor reset drops its waypoint, trace carries on
    wr(tmpc_pkg::OFF_TRACE_EN_CTRL, 32'h0000_0001);
    wr(tmpc_pkg::OFF_MAIN_CONTROL, 32'h0000_0000);
    q.delete();
    cpu_rst = 1'b1;
    send(1, 32'h0000_0500);
    cpu_rst = 1'b0;
    send(2, 32'h0000_0600);
    wait_q(2);
    chk(32'(q.size()), 32'h0000_0002);
    chk(q.size() > 0 ? q[0] : 32'h0, 32'h0000_0600);
    chk({30'h0, ext_out}, 32'h0000_0001);
    summarize();
  end
endmodule
`default_nettype wire

/* hw/tmpc_fifo.sv */
// module: trace word fifo in flip-flops
`default_nettype none
module tmpc_fifo (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  input wire logic push_in,
  input wire logic [31:0] data_in,
  input wire logic pop_in,
  output logic [31:0] data_out,
  output logic full_out,
  output logic empty_out
);
  logic [31:0] mem_q [tmpc_pkg::FIFO_DEPTH];
  logic [31:0] mem_d [tmpc_pkg::FIFO_DEPTH];
  logic [tmpc_pkg::FIFO_PTR_WIDTH-1:0] wr_q, wr_d, rd_q, rd_d, cnt_q, cnt_d;
  logic do_push, do_pop;

  function automatic logic [tmpc_pkg::FIFO_PTR_WIDTH-1:0] ptr_inc(
      input logic [tmpc_pkg::FIFO_PTR_WIDTH-1:0] p);
    if (p == 5'(tmpc_pkg::FIFO_DEPTH - 1)) begin
      return '0;
    end
    return p + 5'h01;
  endfunction

  always_comb begin
    full_out = (cnt_q == 5'(tmpc_pkg::FIFO_DEPTH));
    empty_out = (cnt_q == 5'h00);
    data_out = mem_q[rd_q];
    do_push = push_in && !full_out;
    do_pop = pop_in && !empty_out;
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (do_push) begin
      mem_d[wr_q] = data_in;
      wr_d = ptr_inc(wr_q);
    end
    if (do_pop) begin
      rd_d = ptr_inc(rd_q);
    end
    if (do_push && !do_pop) begin
      cnt_d = cnt_q + 5'h01;
    end else if (do_pop && !do_push) begin
      cnt_d = cnt_q - 5'h01;
    end
    if (flush_in) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      for (int i = 0; i < tmpc_pkg::FIFO_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule
`default_nettype wire

/* hw/tmpc_top.sv */
// module: trace macrocell reset, programming mode and register port
//
// Overview of operation
// - main control reset only by power-on reset
// - after macrocell reset, no trace until reprogrammed
// - trace survives processor reset; last waypoint may drop
// - programming mode drains fifo, then stops trace
// - programming mode freezes counter, sequencer, start/stop
// - programming mode drives external outputs low
// - other register bits clear on system or macrocell reset
// - macrocell reset initialises control, sync, id, management
// - lock access, software and debugger accesses distinguished
// - registers at fixed offsets from integrator base
// - performance event input bus is 52 bits
// - programming bit comes out of reset set
// - fifo full marks overflow, waits for empty
`default_nettype none
module tmpc_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic power_on_reset_n_in,
  input wire logic sys_reset_in,
  input wire logic cpu_reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic paddr_dbg_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic waypoint_valid_in,
  input wire logic [31:0] waypoint_data_in,
  input wire logic [tmpc_pkg::PMU_EVENT_WIDTH-1:0] pmu_event_in,
  input wire logic [3:0] ext_in_in,
  output logic [1:0] ext_out_out,
  output logic trace_valid_out,
  output logic [31:0] trace_data_out,
  input wire logic trace_ready_in
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] mc_q, mc_d, trig_q, trig_d, tec_q, tec_d, prdata_q, prdata_d;
  logic [31:0] tdata_q, tdata_d;
  logic [15:0] cnt_q, cnt_d, exsel_q, exsel_d;
  logic [11:0] sync_q, sync_d;
  logic [6:0] trid_q, trid_d;
  logic [1:0] seq_q, seq_d, extout_q, extout_d;
  logic ss_q, ss_d, itc_q, itc_d, lock_q, lock_d, ovf_q, ovf_d;
  logic tvalid_q, tvalid_d, pready_q;
  tmpc_pkg::tmpc_gen_type st_q, st_d;
  logic macro_rst, prog, gen_en, wp_ok, wr_en, rd_setup, cnt_evt, seq_evt;
  logic fifo_push, fifo_pop, fifo_full, fifo_empty, stat_prog;
  logic [31:0] fifo_din, fifo_dout;

  function automatic logic pick_event(input logic [tmpc_pkg::PMU_EVENT_WIDTH-1:0] bus,
                                      input logic [7:0] idx);
    if (idx >= 8'(tmpc_pkg::PMU_EVENT_WIDTH)) begin
      return 1'b0;
    end
    return bus[idx[5:0]];
  endfunction

  tmpc_fifo u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .flush_in(macro_rst),
    .push_in(fifo_push),
    .data_in(fifo_din),
    .pop_in(fifo_pop),
    .data_out(fifo_dout),
    .full_out(fifo_full),
    .empty_out(fifo_empty)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    macro_rst = !power_on_reset_n_in;
    prog = mc_q[tmpc_pkg::PROG_BIT];
    rd_setup = psel_in && !penable_in;
    // software writes other than to lock access are dropped while locked; debugger passes freely
    wr_en = psel_in && penable_in && pwrite_in &&
            (paddr_dbg_in || !lock_q || paddr_in == tmpc_pkg::OFF_LOCK_ACCESS);
    stat_prog = prog && fifo_empty && !tvalid_q;
    wp_ok = waypoint_valid_in && !cpu_reset_in;
    gen_en = !prog && !mc_q[tmpc_pkg::POWER_DOWN_BIT] && (tec_q[tmpc_pkg::TEC_ALWAYS_BIT] ||
             (tec_q[tmpc_pkg::TEC_STARTSTOP_BIT] && ss_q));
    cnt_evt = pick_event(pmu_event_in, exsel_q[7:0]);
    seq_evt = pick_event(pmu_event_in, exsel_q[15:8]);
    mc_d = mc_q;
    trig_d = trig_q;
    tec_d = tec_q;
    cnt_d = cnt_q;
    exsel_d = exsel_q;
    sync_d = sync_q;
    trid_d = trid_q;
    seq_d = seq_q;
    ss_d = ss_q;
    itc_d = itc_q;
    lock_d = lock_q;
    ovf_d = ovf_q;
    st_d = st_q;
    fifo_push = 1'b0;
    fifo_din = waypoint_data_in;
    // resources move only outside programming mode
    if (!prog) begin
      if (cnt_evt && cnt_q != 16'h0000) begin
        cnt_d = cnt_q - 16'h0001;
      end
      if (seq_evt) begin
        seq_d = seq_q + 2'h1;
      end
      if (ext_in_in[0]) begin
        ss_d = 1'b1;
      end else if (ext_in_in[1]) begin
        ss_d = 1'b0;
      end
    end
    // trace generation
    unique case (st_q)
      tmpc_pkg::TG_HALT: begin
        if (gen_en) begin
          st_d = tmpc_pkg::TG_RUN;
        end
      end
      tmpc_pkg::TG_RUN: begin
        if (!gen_en) begin
          st_d = tmpc_pkg::TG_HALT;
        end else if (wp_ok && fifo_full) begin
          st_d = tmpc_pkg::TG_WAIT;
        end else if (wp_ok) begin
          fifo_push = 1'b1;
        end
      end
      tmpc_pkg::TG_WAIT: begin
        if (fifo_empty) begin
          st_d = tmpc_pkg::TG_MARK;
        end
      end
      tmpc_pkg::TG_MARK: begin
        fifo_push = 1'b1;
        fifo_din = tmpc_pkg::OVERFLOW_MARK;
        st_d = gen_en ? tmpc_pkg::TG_RUN : tmpc_pkg::TG_HALT;
      end
      default: st_d = tmpc_pkg::TG_HALT;
    endcase
    // register writes
    if (wr_en) begin
      unique case (paddr_in)
        tmpc_pkg::OFF_MAIN_CONTROL: mc_d = pwdata_in & tmpc_pkg::MAIN_CONTROL_MASK;
        tmpc_pkg::OFF_TRIGGER: trig_d = pwdata_in;
        tmpc_pkg::OFF_TRACE_EN_CTRL: tec_d = pwdata_in;
        tmpc_pkg::OFF_COUNTER: cnt_d = pwdata_in[15:0];
        tmpc_pkg::OFF_EXT_IN_SEL: exsel_d = pwdata_in[15:0];
        tmpc_pkg::OFF_SYNC_FREQ: sync_d = pwdata_in[11:0];
        tmpc_pkg::OFF_TRACE_ID: trid_d = pwdata_in[6:0];
        tmpc_pkg::OFF_INTEG_CTRL: itc_d = pwdata_in[0];
        tmpc_pkg::OFF_LOCK_ACCESS: lock_d = (pwdata_in != tmpc_pkg::LOCK_KEY);
        tmpc_pkg::OFF_STATUS: begin
          if (pwdata_in[tmpc_pkg::STAT_OVF_BIT]) begin
            ovf_d = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // a new overflow beats a clear in the same cycle
    if (st_q == tmpc_pkg::TG_RUN && gen_en && wp_ok && fifo_full) begin
      ovf_d = 1'b1;
    end
    // system reset clears all but main control, sync, id and management
    if (sys_reset_in || macro_rst) begin
      trig_d = '0;
      tec_d = '0;
      cnt_d = '0;
      exsel_d = '0;
      seq_d = '0;
      ss_d = 1'b0;
      ovf_d = 1'b0;
    end
    if (macro_rst) begin
      mc_d = tmpc_pkg::MAIN_CONTROL_RESET;
      sync_d = tmpc_pkg::SYNC_FREQ_RESET;
      trid_d = tmpc_pkg::TRACE_ID_RESET;
      itc_d = 1'b0;
      lock_d = 1'b1;
      st_d = tmpc_pkg::TG_HALT;
      fifo_push = 1'b0;
    end
    extout_d = prog ? 2'h0 : {ss_q, cnt_q == 16'h0000};
    // output stage keeps draining in programming mode
    fifo_pop = !macro_rst && (!tvalid_q || trace_ready_in) && !fifo_empty;
    tvalid_d = tvalid_q && !trace_ready_in;
    tdata_d = tdata_q;
    if (fifo_pop) begin
      tvalid_d = 1'b1;
      tdata_d = fifo_dout;
    end
    if (macro_rst) begin
      tvalid_d = 1'b0;
    end
    // read data prepared in setup phase; unmapped reads as zero
    prdata_d = prdata_q;
    if (rd_setup) begin
      unique case (paddr_in)
        tmpc_pkg::OFF_MAIN_CONTROL: prdata_d = mc_q;
        tmpc_pkg::OFF_TRIGGER: prdata_d = trig_q;
        tmpc_pkg::OFF_STATUS: prdata_d = {29'h0, ss_q, stat_prog, ovf_q};
        tmpc_pkg::OFF_TRACE_EN_CTRL: prdata_d = tec_q;
        tmpc_pkg::OFF_COUNTER: prdata_d = {16'h0, cnt_q};
        tmpc_pkg::OFF_SYNC_FREQ: prdata_d = {20'h0, sync_q};
        tmpc_pkg::OFF_EXT_IN_SEL: prdata_d = {16'h0, exsel_q};
        tmpc_pkg::OFF_TRACE_ID: prdata_d = {25'h0, trid_q};
        tmpc_pkg::OFF_INTEG_CTRL: prdata_d = {31'h0, itc_q};
        tmpc_pkg::OFF_LOCK_STATUS: prdata_d = {30'h0, lock_q && !paddr_dbg_in, !paddr_dbg_in};
        tmpc_pkg::OFF_DEV_TYPE: prdata_d = tmpc_pkg::DEV_TYPE_VALUE;
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mc_q <= tmpc_pkg::MAIN_CONTROL_RESET;
      trig_q <= '0;
      tec_q <= '0;
      cnt_q <= '0;
      exsel_q <= '0;
      sync_q <= tmpc_pkg::SYNC_FREQ_RESET;
      trid_q <= tmpc_pkg::TRACE_ID_RESET;
      seq_q <= '0;
      ss_q <= 1'b0;
      itc_q <= 1'b0;
      lock_q <= 1'b1;
      ovf_q <= 1'b0;
      st_q <= tmpc_pkg::TG_HALT;
      extout_q <= '0;
      tvalid_q <= 1'b0;
      tdata_q <= '0;
      prdata_q <= '0;
      pready_q <= 1'b0;
    end else begin
      mc_q <= mc_d;
      trig_q <= trig_d;
      tec_q <= tec_d;
      cnt_q <= cnt_d;
      exsel_q <= exsel_d;
      sync_q <= sync_d;
      trid_q <= trid_d;
      seq_q <= seq_d;
      ss_q <= ss_d;
      itc_q <= itc_d;
      lock_q <= lock_d;
      ovf_q <= ovf_d;
      st_q <= st_d;
      extout_q <= extout_d;
      tvalid_q <= tvalid_d;
      tdata_q <= tdata_d;
      prdata_q <= prdata_d;
      pready_q <= 1'b1;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = 1'b0;
  assign ext_out_out = extout_q;
  assign trace_valid_out = tvalid_q;
  assign trace_data_out = tdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_MC_POR: assert property (@(posedge clk_in) disable iff (rst_in)
    !power_on_reset_n_in |=> mc_q == tmpc_pkg::MAIN_CONTROL_RESET && st_q == tmpc_pkg::TG_HALT)
    else $error("macrocell reset did not restore main control");
  AST_MC_SYS_KEEP: assert property (@(posedge clk_in) disable iff (rst_in)
    sys_reset_in && power_on_reset_n_in && !wr_en |=> $stable(mc_q))
    else $error("system reset altered main control");
  AST_SYS_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in)
    sys_reset_in |=> cnt_q == 16'h0000 && tec_q == 32'h0 && !ss_q)
    else $error("system reset left a register set");
  AST_FREEZE: assert property (@(posedge clk_in) disable iff (rst_in)
    prog && !wr_en && !sys_reset_in && power_on_reset_n_in |=> $stable(cnt_q) && $stable(seq_q)
      && $stable(ss_q))
    else $error("resource moved in programming mode");
  AST_EXT_LOW: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(prog) |-> ext_out_out == 2'h0)
    else $error("external output high in programming mode");
  AST_NO_NEW_TRACE: assert property (@(posedge clk_in) disable iff (rst_in)
    prog && st_q != tmpc_pkg::TG_MARK |-> !fifo_push)
    else $error("trace generated in programming mode");
  AST_OVERFLOW: assert property (@(posedge clk_in) disable iff (rst_in)
    st_q == tmpc_pkg::TG_RUN && gen_en && wp_ok && fifo_full && power_on_reset_n_in
      && !sys_reset_in |=> st_q == tmpc_pkg::TG_WAIT && ovf_q)
    else $error("overflow not handled");
  AST_WAIT_EMPTY: assert property (@(posedge clk_in) disable iff (rst_in)
    st_q == tmpc_pkg::TG_WAIT && !fifo_empty && power_on_reset_n_in
      |-> !fifo_push ##1 st_q == tmpc_pkg::TG_WAIT)
    else $error("trace generated before fifo emptied");
  AST_RESET_SILENT: assert property (@(posedge clk_in) disable iff (rst_in)
    !power_on_reset_n_in ##1 power_on_reset_n_in |-> !trace_valid_out ##1 !fifo_push [*2])
    else $error("trace after macrocell reset");
  AST_LOCKED: assert property (@(posedge clk_in) disable iff (rst_in)
    psel_in && penable_in && pwrite_in && !paddr_dbg_in && lock_q && power_on_reset_n_in
      && paddr_in == tmpc_pkg::OFF_TRACE_ID && !sys_reset_in |=> $stable(trid_q))
    else $error("locked software write took effect");
  AST_STATUS_READ: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_setup && paddr_in == tmpc_pkg::OFF_STATUS |=> prdata_out[1] == $past(stat_prog))
    else $error("status programming bit wrong");
endmodule
`default_nettype wire

/* shared/tmpc_pkg.sv */
// package: register map, reset values and sizes of the trace programming control
`default_nettype none
package tmpc_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_MAIN_CONTROL = 12'h000;
  localparam logic [11:0] OFF_TRIGGER = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [11:0] OFF_TRACE_EN_CTRL = 12'h024;
  localparam logic [11:0] OFF_COUNTER = 12'h170;
  localparam logic [11:0] OFF_SYNC_FREQ = 12'h1E0;
  localparam logic [11:0] OFF_EXT_IN_SEL = 12'h1EC;
  localparam logic [11:0] OFF_TRACE_ID = 12'h200;
  localparam logic [11:0] OFF_INTEG_CTRL = 12'hF00;
  localparam logic [11:0] OFF_LOCK_ACCESS = 12'hFB0;
  localparam logic [11:0] OFF_LOCK_STATUS = 12'hFB4;
  localparam logic [11:0] OFF_DEV_TYPE = 12'hFCC;
  // ----------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [31:0] MAIN_CONTROL_RESET = 32'h0000_0401;
  localparam logic [31:0] MAIN_CONTROL_MASK = 32'h3E00_D701;
  localparam int PROG_BIT = 10;
  localparam int POWER_DOWN_BIT = 0;
  localparam logic [11:0] SYNC_FREQ_RESET = 12'h400;
  localparam logic [6:0] TRACE_ID_RESET = 7'h00;
  localparam logic [31:0] DEV_TYPE_VALUE = 32'h0000_0013;
  localparam logic [31:0] LOCK_KEY = 32'hC5AC_CE55;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_PROG_BIT = 1;
  localparam int STAT_STARTSTOP_BIT = 2;
  localparam int TEC_ALWAYS_BIT = 0;
  localparam int TEC_STARTSTOP_BIT = 1;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int PMU_EVENT_WIDTH = 52;
  localparam int FIFO_DEPTH = 18;
  localparam int FIFO_PTR_WIDTH = 5;
  localparam logic [31:0] OVERFLOW_MARK = 32'h0000_0005;
  typedef enum logic [3:0] {
    TG_HALT = 4'h1,
    TG_RUN = 4'h2,
    TG_WAIT = 4'h4,
    TG_MARK = 4'h8
  } tmpc_gen_type;
endpackage
`default_nettype wire
